// ===== rtl/flash_cycle_engine.sv
/*
 * one asynchronous flash bus cycle per start: a command write or a read.
 * assumes start is offered only while done is low and the engine is idle.
 */
module flash_cycle_engine
   import flash_host_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   flash_cycle_if.eng cyc,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [23:0] flash_addr,
   output logic [15:0] dq_o,
   output logic dq_oe,
   input wire logic [15:0] dq_i
);
   eng_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic wr_reg, wr_next;
   logic ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next, dq_oe_reg, dq_oe_next;
   logic [23:0] addr_reg, addr_next;
   logic [15:0] dq_o_reg, dq_o_next, rdata_reg, rdata_next;
   logic done_reg, done_next;
   logic [15:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;

   // a data bit is taken only once two late stages agree
   genvar b;
   generate
      for (b = 0; b < 16; b++) begin : g_sync
         always_comb begin
            filt_next[b] = (s2_reg[b] == s3_reg[b]) ? s3_reg[b] : filt_reg[b];
         end
      end
   endgenerate

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      wr_next = wr_reg;
      ce_n_next = ce_n_reg;
      oe_n_next = oe_n_reg;
      we_n_next = we_n_reg;
      dq_oe_next = dq_oe_reg;
      addr_next = addr_reg;
      dq_o_next = dq_o_reg;
      rdata_next = rdata_reg;
      done_next = 1'b0;
      case (state_reg)
         E_IDLE: begin
            if (cyc.start) begin
               wr_next = cyc.write;
               addr_next = cyc.addr;
               dq_o_next = cyc.wdata;
               dq_oe_next = cyc.write;
               ce_n_next = 1'b0;
               state_next = E_SETUP;
            end
         end
         E_SETUP: begin
            cnt_next = 4'h1;
            if (wr_reg) begin
               we_n_next = 1'b0;
            end else begin
               oe_n_next = 1'b0; // falling oe latches fresh status
            end
            state_next = E_PULSE;
         end
         E_PULSE: begin
            cnt_next = cnt_reg + 4'h1;
            if (wr_reg ? (cnt_reg == WE_CYC) : (cnt_reg == RD_CYC)) begin
               if (!wr_reg) begin
                  rdata_next = filt_next;
               end
               we_n_next = 1'b1;
               oe_n_next = 1'b1; // oe released so the next read relatches
               state_next = E_HOLD;
            end
         end
         E_HOLD: begin
            ce_n_next = 1'b1;
            dq_oe_next = 1'b0;
            done_next = 1'b1;
            state_next = E_IDLE;
         end
         default: begin
            state_next = E_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      s1_reg <= dq_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (reset) begin
         state_reg <= E_IDLE;
         cnt_reg <= 4'h0;
         wr_reg <= 1'b0;
         ce_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         dq_oe_reg <= 1'b0;
         addr_reg <= 24'h000000;
         dq_o_reg <= 16'h0000;
         rdata_reg <= 16'h0000;
         done_reg <= 1'b0;
         filt_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         wr_reg <= wr_next;
         ce_n_reg <= ce_n_next;
         oe_n_reg <= oe_n_next;
         we_n_reg <= we_n_next;
         dq_oe_reg <= dq_oe_next;
         addr_reg <= addr_next;
         dq_o_reg <= dq_o_next;
         rdata_reg <= rdata_next;
         done_reg <= done_next;
         filt_reg <= filt_next;
      end
   end

   assign ce_n = ce_n_reg;
   assign oe_n = oe_n_reg;
   assign we_n = we_n_reg;
   assign dq_oe = dq_oe_reg;
   assign flash_addr = addr_reg;
   assign dq_o = dq_o_reg;
   assign cyc.done = done_reg;
   assign cyc.rdata = rdata_reg;

   sequence s_read_start;
      state_reg == E_IDLE && cyc.start && !cyc.write;
   endsequence
   property p_read_strobe;
      @(posedge clk) disable iff (reset)
      s_read_start |=> (!ce_n_reg && oe_n_reg) ##1 (!oe_n_reg) [*6] ##1 oe_n_reg ##1 ce_n_reg;
   endproperty
   a_read_strobe: assert property (p_read_strobe) else $error("read strobe length wrong");

   property p_no_contention;
      @(posedge clk) disable iff (reset)
      !(dq_oe_reg && !oe_n_reg);
   endproperty
   a_no_contention: assert property (p_no_contention) else $error("data driven during read");

   property p_write_pulse;
      @(posedge clk) disable iff (reset)
      $fell(we_n_reg) |-> (!we_n_reg && dq_oe_reg && !ce_n_reg) [*2] ##1 we_n_reg;
   endproperty
   a_write_pulse: assert property (p_write_pulse) else $error("write pulse length wrong");
endmodule : flash_cycle_engine

// ===== rtl/flash_cycle_if.sv
/*
 * carrier between the controller core and the pin cycle engine.
 * assumes both ends run on the same clock.
 */
interface flash_cycle_if;
   logic start;
   logic write;
   logic [23:0] addr;
   logic [15:0] wdata;
   logic done;
   logic [15:0] rdata;
   modport ctl(output start, output write, output addr, output wdata, input done, input rdata);
   modport eng(input start, input write, input addr, input wdata, output done, output rdata);
endinterface : flash_cycle_if

// ===== rtl/flash_host_ctrl.sv
/*
 * host controller for an asynchronous parallel nor flash: software orders
 * command writes, reads and status polls over axi4-lite; identifier and
 * status read modes are tracked and the status byte is masked on the way in.
 * assumes the flash answers within the access time and one axi master.
 */
// What this block does
// - after identifier command every read gives identifier data until next command.
// - identifier command only while write engine idle or suspended.
// - after status command every read returns status until next command.
// - status latched on oe fall; host toggles oe before each fresh read.
// - host masks reserved status bit 0 when polling.
module flash_host_ctrl
   import flash_host_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic chip_enable_0_n,
   output logic chip_enable_1,
   output logic chip_enable_2,
   output logic oe_n,
   output logic we_n,
   output logic [23:0] flash_addr,
   output logic [15:0] dq_o,
   output logic dq_oe,
   input wire logic [15:0] dq_i,
   input wire logic ready_indicator_pin,
   output logic program_supply_enable
);
   flash_cycle_if cyc();

   top_state_t state_reg, state_next;
   logic [1:0] op_reg, op_next;
   logic start_reg, start_next;
   logic [23:0] faddr_reg, faddr_next;
   logic [15:0] wdata_reg, wdata_next, result_reg, result_next;
   logic [7:0] fstat_reg, fstat_next;
   logic supply_reg, supply_next, refused_reg, refused_next;
   logic id_mode_reg, id_mode_next, sr_mode_reg, sr_mode_next, busy_seen_reg, busy_seen_next;
   logic aw_got_reg, aw_got_next, w_got_reg, w_got_next, bvalid_reg, bvalid_next;
   logic awready_reg, awready_next, wready_reg, wready_next, strb_reg, strb_next;
   logic [7:0] awaddr_reg, awaddr_next;
   logic [31:0] wd_reg, wd_next, rdata_reg, rdata_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic arready_reg, arready_next, rvalid_reg, rvalid_next;
   logic pin1_reg, pin2_reg, pin3_reg, pin_reg, pin_next;
   logic wr_fire, ar_fire, order, refuse;
   logic [1:0] new_op;
   logic [7:0] raw_sr;

   flash_cycle_engine u_engine (
      .clk(clk),
      .reset(reset),
      .cyc(cyc),
      .ce_n(chip_enable_0_n),
      .oe_n(oe_n),
      .we_n(we_n),
      .flash_addr(flash_addr),
      .dq_o(dq_o),
      .dq_oe(dq_oe),
      .dq_i(dq_i)
   );

   assign cyc.start = start_reg;
   assign cyc.write = (op_reg == OP_WRITE);
   assign cyc.addr = faddr_reg;
   assign cyc.wdata = wdata_reg;

   always_comb begin
      wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
      ar_fire = s_axi_arvalid && arready_reg;
      new_op = wd_reg[CTRL_OP_LSB +: 2];
      // strobes are kept from the data beat; the bus may change them once it is taken
      order = wr_fire && awaddr_reg == ADDR_CTRL && strb_reg && new_op != OP_NONE;
      // identifier and clear-status need an idle or suspended engine
      refuse = order && state_reg == T_IDLE && new_op == OP_WRITE && busy_seen_reg &&
               (wdata_reg[7:0] == CMD_READ_ID || wdata_reg[7:0] == CMD_CLEAR_STATUS);
      raw_sr = cyc.rdata[7:0];
      pin_next = (pin2_reg == pin3_reg) ? pin3_reg : pin_reg;
      aw_got_next = aw_got_reg;
      w_got_next = w_got_reg;
      awaddr_next = awaddr_reg;
      wd_next = wd_reg;
      strb_next = strb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      arready_next = arready_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      state_next = state_reg;
      op_next = op_reg;
      start_next = 1'b0;
      faddr_next = faddr_reg;
      wdata_next = wdata_reg;
      supply_next = supply_reg;
      result_next = result_reg;
      fstat_next = fstat_reg;
      id_mode_next = id_mode_reg;
      sr_mode_next = sr_mode_reg;
      busy_seen_next = busy_seen_reg;
      refused_next = refused_reg;
      if (s_axi_awvalid && !aw_got_reg && !bvalid_reg) begin
         aw_got_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_reg && !bvalid_reg) begin
         w_got_next = 1'b1;
         wd_next = s_axi_wdata;
         strb_next = s_axi_wstrb != 4'h0;
      end
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (wr_fire) begin
         aw_got_next = 1'b0;
         w_got_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = RESP_OKAY;
         case (awaddr_reg)
            ADDR_CTRL: supply_next = wd_reg[CTRL_SUPPLY_BIT];
            ADDR_FADDR: faddr_next = wd_reg[23:0];
            ADDR_WDATA: wdata_next = wd_reg[15:0];
            ADDR_STAT: begin
               if (wd_reg[STAT_REFUSED_BIT]) begin
                  refused_next = 1'b0;
               end
            end
            ADDR_RESULT, ADDR_FSTAT: bresp_next = RESP_OKAY;
            default: bresp_next = RESP_SLVERR;
         endcase
      end
      if (refuse) begin
         refused_next = 1'b1; // set wins over a same-cycle clear
      end else if (order && state_reg == T_IDLE) begin
         op_next = new_op;
         start_next = 1'b1;
         state_next = T_RUN;
         if (new_op == OP_WRITE) begin
            // read mode persists until the next command byte
            id_mode_next = (wdata_reg[7:0] == CMD_READ_ID);
            sr_mode_next = (wdata_reg[7:0] == CMD_READ_STATUS);
         end
      end
      if (state_reg == T_RUN && cyc.done) begin
         state_next = T_IDLE;
         if (op_reg != OP_WRITE) begin
            result_next = id_mode_reg ? {8'h00, cyc.rdata[7:0]} : cyc.rdata;
            if (sr_mode_reg || op_reg == OP_POLL) begin
               busy_seen_next = !raw_sr[SR_READY_BIT];
               // while busy only the ready bit carries meaning; bit 0 always masked
               fstat_next = raw_sr[SR_READY_BIT] ? {raw_sr[7:1], 1'b0} : 8'h00;
            end
            if (op_reg == OP_POLL && !raw_sr[SR_READY_BIT]) begin
               start_next = 1'b1; // oe already toggled high, so this read relatches
               state_next = T_RUN;
            end
         end
      end
      if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
         arready_next = 1'b1;
      end
      if (ar_fire) begin
         arready_next = 1'b0;
         rvalid_next = 1'b1;
         rresp_next = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_CTRL: rdata_next = {27'h0, supply_reg, 2'h0, op_reg};
            ADDR_FADDR: rdata_next = {8'h00, faddr_reg};
            ADDR_WDATA: rdata_next = {16'h0000, wdata_reg};
            ADDR_STAT: rdata_next = {27'h0, pin_reg, sr_mode_reg, id_mode_reg, refused_reg, state_reg == T_RUN};
            ADDR_RESULT: rdata_next = {16'h0000, result_reg};
            ADDR_FSTAT: rdata_next = {23'h0, fstat_reg[SR_ERASE_ERR_BIT] && fstat_reg[SR_PROG_ERR_BIT],
                                      fstat_reg};
            default: begin
               rdata_next = 32'h0000_0000;
               rresp_next = RESP_SLVERR;
            end
         endcase
      end
      // readies come from flops that already hold next cycle's acceptance
      awready_next = !aw_got_next && !bvalid_next;
      wready_next = !w_got_next && !bvalid_next;
   end

   always_ff @(posedge clk) begin
      pin1_reg <= ready_indicator_pin;
      pin2_reg <= pin1_reg;
      pin3_reg <= pin2_reg;
      if (reset) begin
         state_reg <= T_IDLE;
         op_reg <= OP_NONE;
         start_reg <= 1'b0;
         faddr_reg <= 24'h000000;
         wdata_reg <= 16'h0000;
         result_reg <= 16'h0000;
         fstat_reg <= 8'h00;
         supply_reg <= 1'b0;
         refused_reg <= 1'b0;
         id_mode_reg <= 1'b0;
         sr_mode_reg <= 1'b0;
         busy_seen_reg <= 1'b0;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wd_reg <= 32'h0000_0000;
         strb_reg <= 1'b0;
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
         pin_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         start_reg <= start_next;
         faddr_reg <= faddr_next;
         wdata_reg <= wdata_next;
         result_reg <= result_next;
         fstat_reg <= fstat_next;
         supply_reg <= supply_next;
         refused_reg <= refused_next;
         id_mode_reg <= id_mode_next;
         sr_mode_reg <= sr_mode_next;
         busy_seen_reg <= busy_seen_next;
         aw_got_reg <= aw_got_next;
         w_got_reg <= w_got_next;
         awaddr_reg <= awaddr_next;
         wd_reg <= wd_next;
         strb_reg <= strb_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         pin_reg <= pin_next;
      end
   end

   // chip enables 1 and 2 are parked at their enabling level; only enable 0 strobes
   assign chip_enable_1 = 1'b0;
   assign chip_enable_2 = 1'b0;
   assign program_supply_enable = supply_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   property p_sr0_masked;
      @(posedge clk) disable iff (reset)
      fstat_reg[SR_RESERVED_BIT] == 1'b0;
   endproperty
   a_sr0_masked: assert property (p_sr0_masked) else $error("reserved status bit not masked");

   property p_busy_masked;
      @(posedge clk) disable iff (reset)
      (state_reg == T_RUN && cyc.done && op_reg == OP_POLL && !raw_sr[SR_READY_BIT]) |=> fstat_reg == 8'h00;
   endproperty
   a_busy_masked: assert property (p_busy_masked) else $error("busy status bits leaked");

   property p_id_upper_zero;
      @(posedge clk) disable iff (reset)
      (state_reg == T_RUN && cyc.done && id_mode_reg && op_reg == OP_READ) |=> result_reg[15:8] == 8'h00;
   endproperty
   a_id_upper_zero: assert property (p_id_upper_zero) else $error("id upper byte not zero");

   property p_refuse_no_start;
      @(posedge clk) disable iff (reset)
      refuse |=> !start_reg && refused_reg && state_reg == T_IDLE;
   endproperty
   a_refuse_no_start: assert property (p_refuse_no_start) else $error("refused command was started");

   sequence s_poll_busy;
      state_reg == T_RUN && cyc.done && op_reg == OP_POLL && !raw_sr[SR_READY_BIT];
   endsequence
   property p_poll_repeats;
      @(posedge clk) disable iff (reset)
      s_poll_busy |=> start_reg && state_reg == T_RUN ##2 !oe_n ##[1:12] cyc.done;
   endproperty
   a_poll_repeats: assert property (p_poll_repeats) else $error("poll did not reread");

   property p_bresp_follows;
      @(posedge clk) disable iff (reset)
      wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
   endproperty
   a_bresp_follows: assert property (p_bresp_follows) else $error("write response missing");

   property p_mode_kept;
      @(posedge clk) disable iff (reset)
      (sr_mode_reg && !(order && new_op == OP_WRITE)) |=> sr_mode_reg;
   endproperty
   a_mode_kept: assert property (p_mode_kept) else $error("status mode lost without command");

   property p_id_mode_set;
      @(posedge clk) disable iff (reset)
      (order && !refuse && state_reg == T_IDLE && new_op == OP_WRITE && wdata_reg[7:0] == CMD_READ_ID)
         |=> id_mode_reg ##2 !we_n [*2];
   endproperty
   a_id_mode_set: assert property (p_id_mode_set) else $error("id mode not entered");
endmodule : flash_host_ctrl

// ===== rtl/flash_host_pkg.sv
/*
 * shared constants and types of the flash host controller: register map,
 * flash command bytes, pin timing and state encodings.
 * assumes a 20 MHz system clock and an asynchronous x16 parallel flash.
 */
package flash_host_pkg;
   // register byte offsets on the axi4-lite slave
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FADDR = 8'h04;
   localparam logic [7:0] ADDR_WDATA = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0C;
   localparam logic [7:0] ADDR_RESULT = 8'h10;
   localparam logic [7:0] ADDR_FSTAT = 8'h14;
   // ctrl fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_SUPPLY_BIT = 4;
   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_POLL = 2'h3;
   // stat fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_REFUSED_BIT = 1;
   localparam int STAT_ID_MODE_BIT = 2;
   localparam int STAT_SR_MODE_BIT = 3;
   localparam int STAT_PIN_BIT = 4;
   localparam int FSTAT_IMPROPER_BIT = 8;
   // operation_status bit positions
   localparam int SR_READY_BIT = 7;
   localparam int SR_ERASE_ERR_BIT = 5;
   localparam int SR_PROG_ERR_BIT = 4;
   localparam int SR_RESERVED_BIT = 0;
   // flash command bytes; only clear-status is fixed, the others are plain defaults
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY = 8'h98;
   localparam logic [7:0] QUERY_SIG_OFFSET = 8'h31;
   // pin timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_ACC_NS = 150;
   localparam int T_WP_NS = 70;
   localparam int SYNC_CYC = 3;
   localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] WE_CYC = 4'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] RD_CYC = 4'(ACC_CYC + 4'(SYNC_CYC));
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      E_IDLE = 4'b0001,
      E_SETUP = 4'b0010,
      E_PULSE = 4'b0100,
      E_HOLD = 4'b1000
   } eng_state_t;

   typedef enum logic [1:0] {
      T_IDLE = 2'b01,
      T_RUN = 2'b10
   } top_state_t;
endpackage : flash_host_pkg

// ===== tb/flash_dev_model.sv
/*
 flash device model: command modes, identifier, query and status reads.
 assumes ce_n already folds the three chip enables; no clock of its own.
*/
module flash_dev_model #(
   parameter logic [7:0] MFR = 8'h3E, // arbitrary
   parameter logic [7:0] DEV = 8'h5D // arbitrary
) (
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [23:0] addr,
   input wire logic [15:0] dq_in,
   input wire logic engine_busy,
   input wire logic [7:0] sr_init,
   input wire logic blk_locked,
   output logic ready_pin,
   output logic [15:0] dq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // buffer-write setup byte is a plain default
   localparam logic [7:0] BUF_SETUP = 8'hE8;
   typedef enum logic [2:0] {M_ARR, M_ID, M_SR, M_QRY, M_XS} mode_t;
   mode_t mode = M_ARR;
   logic [7:0] sr;
   logic [7:0] sr_clr = 8'h00;
   logic [7:0] latch;
   logic [15:0] last = 16'h0;
   assign ready_pin = ~engine_busy;
   // error bits once cleared stay clear; a level view avoids a time-zero race on sr_init
   assign sr = sr_init & ~sr_clr;
   always @(posedge we_n) if (!ce_n) begin
      case (dq_in[7:0])
         8'h50: sr_clr = 8'h3A;
         BUF_SETUP: mode = M_XS;
         8'h70: mode = M_SR;
         8'h90: mode = M_ID;
         8'h98: mode = M_QRY;
         default: mode = M_ARR;
      endcase
   end
   always @(negedge oe_n or negedge ce_n) latch = engine_busy ? 8'h00 : sr;
   always @(posedge oe_n) last = dq_out;
   function automatic logic [7:0] qry(input logic [7:0] o);
      case (o)
         8'h31: return 8'h50;
         8'h32: return 8'h52;
         8'h33: return 8'h49;
         8'h34, 8'h35: return 8'h31;
         8'h36: return 8'hCE;
         8'h3A, 8'h3B, 8'h3F: return 8'h01;
         8'h3D: return 8'h33;
         8'h44: return 8'h03;
         default: return 8'h00;
      endcase
   endfunction : qry
   // released lines show the inverse of the last value, never a stale copy
   always @* begin
      if (ce_n || oe_n) dq_out = ~last;
      else if (mode == M_SR) dq_out = latch[7] ? {8'h00, latch} : {~last[15:8], 1'b0, ~last[6:0]};
      else if (mode == M_ID) dq_out = {8'h00, addr[2:1] == 2'd0 ? MFR : addr[2:1] == 2'd1 ? DEV : {7'h0, blk_locked}};
      else if (mode == M_XS) dq_out = 16'h0080;
      else if (mode == M_QRY) dq_out = {8'h00, qry(addr[8:1])};
      else dq_out = {addr[7:0], ~addr[7:0]};
   end
endmodule : flash_dev_model

// ===== tb/tb_flash_host_ctrl.sv
/*
 testbench of the flash host controller over axi4-lite with a flash model.
 assumes the controller answers each axi request within the watchdog span.
*/
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_flash_host_ctrl import flash_host_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] MFR = 8'h3E; // arbitrary
   localparam logic [7:0] DEV = 8'h5D; // arbitrary
   logic clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, engine_busy;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic chip_enable_0_n, chip_enable_1, chip_enable_2, oe_n, we_n, dq_oe, ready_indicator_pin, program_supply_enable;
   logic [23:0] flash_addr;
   logic [15:0] dq_o, dq_i, dev_dq;
   int fail_count, total_checks, t0;
   assign dq_i = dq_oe ? dq_o : dev_dq;
   flash_host_ctrl flash_host_ctrl_i(.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_enable_0_n,
      .chip_enable_1, .chip_enable_2, .oe_n, .we_n, .flash_addr, .dq_o, .dq_oe, .dq_i, .ready_indicator_pin,
      .program_supply_enable);
   flash_dev_model #(.MFR(MFR), .DEV(DEV)) flash_dev_model_i(.ce_n(chip_enable_0_n | chip_enable_1 | chip_enable_2),
      .oe_n(oe_n), .we_n(we_n), .addr(flash_addr), .dq_in(dq_i), .engine_busy(engine_busy), .sr_init(8'hB1),
      .blk_locked(1'b1), .ready_pin(ready_indicator_pin), .dq_out(dev_dq));
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, dd;
      ad = 0;
      dd = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (!(ad && dd)) begin
         @(posedge clk);
         if (s_axi_awready && !ad) begin ad = 1; s_axi_awvalid <= 0; end
         if (s_axi_wready && !dd) begin dd = 1; s_axi_wvalid <= 0; end
      end
      do @(posedge clk); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask : rdr
   task automatic op(input logic [1:0] o, input logic [23:0] fa, input logic [7:0] c, input logic sup);
      wr(ADDR_FADDR, 32'(fa));
      wr(ADDR_WDATA, {24'h0, c});
      wr(ADDR_CTRL, 32'(o) | (32'(sup) << CTRL_SUPPLY_BIT));
      repeat (2) @(posedge clk);
      do rdr(ADDR_STAT); while (rd[STAT_BUSY_BIT] !== 1'b0);
   endtask : op
   task results;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results();
   end
   initial begin
      logic [7:0] cm[8] = '{CMD_READ_ID, CMD_READ_ID, CMD_READ_ID, CMD_READ_QUERY, CMD_READ_QUERY, CMD_READ_QUERY,
         CMD_READ_QUERY, 8'hE8};
      logic [23:0] fa[8] = '{24'h1, 24'h2, 24'h40004, 24'h62, 24'h88, 24'h68, 24'h6C, 24'h0};
      logic [15:0] ex[8] = '{{8'h0, MFR}, {8'h0, DEV}, 16'h1, 16'h50, 16'h3, 16'h31, 16'hCE, 16'h80};
      {reset, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, engine_busy} = 5'b10000;
      {s_axi_bready, s_axi_rready, s_axi_wstrb, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {6'h3F, 48'h0};
      repeat (8) @(posedge clk);
      reset <= 0;
      @(posedge clk);
      rdr(ADDR_STAT);
      `CHK(rd[4:0], 5'h10)
      rdr(8'h3C);
      `CHK(rsp, RESP_SLVERR)
      wr(8'h3C, 32'h1);
      `CHK(rsp, RESP_SLVERR)
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         op(OP_WRITE, 24'h0, cm[i], 1'b1);
         op(OP_READ, fa[i], 8'h00, 1'b1);
         rdr(ADDR_RESULT);
         `CHK(rd[15:0], ex[i])
      end
      `CHK(program_supply_enable, 1'b1)
      $display("test identifier and query done");
      op(OP_WRITE, 24'h0, CMD_READ_STATUS, 1'b0);
      rdr(ADDR_STAT);
      `CHK(rd[STAT_SR_MODE_BIT], 1'b1)
      engine_busy <= 1;
      t0 = $time;
      fork
         op(OP_POLL, 24'h0, 8'h00, 1'b0);
         begin repeat (60) @(posedge clk); engine_busy <= 0; end
      join
      `CHK($time - t0 > 3000, 1'b1)
      rdr(ADDR_FSTAT);
      `CHK(rd, 32'h1B0)
      engine_busy <= 1;
      op(OP_READ, 24'h0, 8'h00, 1'b0);
      op(OP_WRITE, 24'h0, CMD_READ_ID, 1'b0);
      rdr(ADDR_STAT);
      `CHK(rd[3:1], 3'b101)
      engine_busy <= 0;
      wr(ADDR_STAT, 32'h2);
      op(OP_POLL, 24'h0, 8'h00, 1'b0);
      rdr(ADDR_STAT);
      `CHK(rd[3:1], 3'b100)
      $display("test status poll done");
      op(OP_WRITE, 24'h0, CMD_CLEAR_STATUS, 1'b0);
      op(OP_POLL, 24'h0, 8'h00, 1'b0);
      rdr(ADDR_FSTAT);
      `CHK(rd, 32'h80)
      $display("test clear status done");
      results();
   end
endmodule : tb_flash_host_ctrl
